// ===== rtl/mac_pkg.sv
// Overview of operation
// - Chain multiply writes product-high only, source untouched.
// - Chain multiply rounds the upper product word.
// - Chain operand length is chain length plus two.
// - Rounded multiply never alters the source accumulator.
// - Rounded multiply stores rounded upper word in product-high for accumulator sources only.
// - Index register steps by two bytes once per memory-source operation.
// - Word multiply-add adds product-low into destination accumulator.
// - Add and subtract forms update overflow, sign, zero, carry.
// - Memory source sets tag from seventeenth word bit.
// - Word multiply-subtract subtracts product-low from destination.
// - Pointer modifier adjusts accumulator pointer before multiplying.
// - Memory chain add walks words from index address.
// - Accumulator chain add uses offset accumulator string source.
// - Single-word multiply rounds only for accumulator sources.
package mac_pkg;

   // =========================================================
   // Widths, sizes and constants
   localparam int          DATA_W     = 16;
   localparam int          ACC_WORDS  = 32;
   localparam int          PTR_COUNT  = 4;
   localparam int          TAG_BIT    = 16;
   localparam logic [4:0]  CHAIN_XTRA = 5'h02;
   localparam logic [15:0] ADDR_STEP  = 16'h0002;
   localparam logic [4:0]  ACC_OFFSET = 5'h10;
   localparam logic [15:0] SAT_POS    = 16'h7fff;
   localparam logic [15:0] RST_WORD   = 16'h0000;
   localparam logic [4:0]  RST_PTR    = 5'h00;
   localparam logic [3:0]  RST_LEN    = 4'h0;

   // =========================================================
   // Operations
   typedef enum logic [2:0]
   {
      OP_ROUND_MUL = 3'b000, // rounded_multiply_op
      OP_CHAIN_MUL = 3'b001, // chain_multiply_op
      OP_MAC_ADD   = 3'b010, // multiply_add_low_op
      OP_CHAIN_ADD = 3'b011, // chain_multiply_add_low_op
      OP_MAC_SUB   = 3'b100, // multiply_subtract_low_op
      OP_CHAIN_SUB = 3'b101  // chain_multiply_subtract_low_op
   } mac_op_t;

   // Pointer and index modifiers.
   typedef enum logic [1:0]
   {
      MOD_NONE = 2'b00,
      MOD_INC  = 2'b01,
      MOD_DEC  = 2'b10
   } mac_mod_t;

   // Sequencer states.
   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b000,
      ST_PREMOD = 3'b001,
      ST_FETCH  = 3'b010,
      ST_EXEC   = 3'b011,
      ST_DONE   = 3'b100
   } mac_state_t;

endpackage

// ===== rtl/mac_mul.sv
`timescale 1ns/1ps
// =========================================================
// One word step of a multiword product: operand times word plus carry.
module mac_mul
   import mac_pkg::*;
(
   // Operands
   input  logic [15:0] mult_i,
   input  logic [15:0] word_i,
   input  logic        word_signed_i,
   input  logic [15:0] carry_i,
   // Result
   output logic [15:0] low_o,
   output logic [15:0] high_o
);

   logic signed [33:0] mult_ext;
   logic signed [33:0] word_ext;
   logic signed [33:0] carry_ext;
   logic signed [33:0] prod;

   // Lower string words are magnitudes; only the top word carries sign.
   // Operands are widened first so the product keeps all of its bits.
   assign mult_ext  = {{18{mult_i[15]}}, mult_i};
   assign word_ext  = word_signed_i ? {{18{word_i[15]}}, word_i}
                                    : {18'h00000, word_i};
   assign carry_ext = {{18{carry_i[15]}}, carry_i};
   assign prod      = mult_ext * word_ext + carry_ext;
   assign low_o    = prod[15:0];
   assign high_o   = prod[31:16];

endmodule // mac_mul

// ===== rtl/mac_addsub.sv
`timescale 1ns/1ps
// =========================================================
// One word step of a string add or subtract with carry chaining.
module mac_addsub
   import mac_pkg::*;
(
   // Operands
   input  logic [15:0] a_i,
   input  logic [15:0] b_i,
   input  logic        sub_i,
   input  logic        carry_i,
   // Result
   output logic [15:0] sum_o,
   output logic        carry_o,
   output logic        ovf_o
);

   logic [15:0] b_x;
   logic [16:0] total;

   // Subtraction is addition of the complement with carry in set.
   assign b_x     = sub_i ? ~b_i : b_i;
   assign total   = {1'b0, a_i} + {1'b0, b_x} + {16'h0000, carry_i};
   assign sum_o   = total[15:0];
   assign carry_o = total[16];
   assign ovf_o   = (a_i[15] == b_x[15]) && (total[15] != a_i[15]);

endmodule // mac_addsub

// ===== rtl/mac_unit.sv
`timescale 1ns/1ps
// =========================================================
// Multiply-accumulate unit with accumulator string file.
module mac_unit
   import mac_pkg::*;
(
   // Clock and reset
   input  logic        mclk_i,
   input  logic        nrst_i,
   // Operation issue
   input  logic        op_valid_i,
   input  mac_op_t     op_code_i,
   input  logic        src_mem_i,
   input  logic [1:0]  acc_select_i,
   input  logic        src_offset_i,
   input  logic        dst_offset_i,
   input  mac_mod_t    ptr_mod_i,
   input  mac_mod_t    idx_mod_i,
   output logic        op_ready_o,
   output logic        op_done_o,
   // Register loads, taken while idle
   input  logic        mult_load_i,
   input  logic [15:0] mult_value_i,
   input  logic        chain_len_load_i,
   input  logic [3:0]  chain_len_value_i,
   input  logic        idx_load_i,
   input  logic [15:0] idx_value_i,
   input  logic        ptr_load_i,
   input  logic [4:0]  ptr_value_i,
   // Accumulator file access, writes taken while idle
   input  logic        acc_wr_i,
   input  logic [4:0]  acc_wr_addr_i,
   input  logic [15:0] acc_wr_data_i,
   input  logic [4:0]  acc_rd_addr_i,
   output logic [15:0] acc_rd_data_o,
   // Data memory read port
   output logic        mem_rd_o,
   output logic [15:0] mem_addr_o,
   input  logic [16:0] mem_rdata_i,
   input  logic        mem_rvalid_i,
   // Results and status
   output logic [15:0] product_high_o,
   output logic [15:0] product_low_o,
   output logic [15:0] index_reg_three_o,
   output logic        overflow_flag_o,
   output logic        sign_flag_o,
   output logic        zero_flag_o,
   output logic        carry_flag_o,
   output logic        tag_flag_o
);

   // =========================================================
   // State
   mac_state_t  state;
   logic [15:0] multiplier_operand_reg;
   logic [15:0] product_high_reg;
   logic [15:0] product_low_reg;
   logic [15:0] index_reg_three;
   logic [3:0]  chain_length_reg;
   logic [4:0]  accumulator_pointer [PTR_COUNT];
   logic [15:0] acc_ram [ACC_WORDS];
   mac_op_t     cur_op;
   mac_mod_t    cur_ptr_mod;
   mac_mod_t    cur_idx_mod;
   logic        cur_mem;
   logic [1:0]  cur_sel;
   logic        cur_src_off;
   logic        cur_dst_off;
   logic [4:0]  word_idx;
   logic [4:0]  last_idx;
   logic [15:0] mul_carry;
   logic        add_carry;
   logic        zero_run;
   logic [15:0] mem_word;
   logic [15:0] mem_addr;
   logic        overflow_flag;
   logic        sign_flag;
   logic        zero_flag;
   logic        carry_flag;
   logic        tag_flag;

   // Word address of a string element, optionally in the offset bank.
   function automatic logic [4:0] acc_addr(input logic [4:0] base,
                                           input logic       off,
                                           input logic [4:0] idx);
      acc_addr = (off ? (base ^ ACC_OFFSET) : base) + idx;
   endfunction

   function automatic logic op_is_chain(input mac_op_t op);
      op_is_chain = (op == OP_CHAIN_MUL) || (op == OP_CHAIN_ADD)
                 || (op == OP_CHAIN_SUB);
   endfunction

   function automatic logic op_is_sub(input mac_op_t op);
      op_is_sub = (op == OP_MAC_SUB) || (op == OP_CHAIN_SUB);
   endfunction

   // =========================================================
   // Datapath
   logic        accept;
   logic        exec;
   logic        last;
   logic        is_mac;
   logic        do_round;
   logic        acc_we;
   logic [4:0]  src_addr;
   logic [4:0]  dst_addr;
   logic [15:0] src_word;
   logic [15:0] dst_word;
   logic [15:0] mul_low;
   logic [15:0] mul_high;
   logic [15:0] sum;
   logic        sum_carry;
   logic        sum_ovf;
   logic [15:0] rounded_high;

   // Decode of the operation in flight.
   assign accept   = op_valid_i && (state == ST_IDLE);
   assign exec     = (state == ST_EXEC);
   assign last     = (word_idx == last_idx);
   assign is_mac   = (cur_op != OP_ROUND_MUL) && (cur_op != OP_CHAIN_MUL);
   assign do_round = ((cur_op == OP_ROUND_MUL) && !cur_mem)
                  || (cur_op == OP_CHAIN_MUL);
   // Only the accumulate forms ever write the accumulator file.
   assign acc_we   = exec && is_mac;

   // Source comes from memory or from the accumulator string, offset when src_offset_i is set.
   assign src_addr = acc_addr(accumulator_pointer[cur_sel], cur_src_off,
                              word_idx);
   assign dst_addr = acc_addr(accumulator_pointer[cur_sel], cur_dst_off,
                              word_idx);
   assign src_word = cur_mem ? mem_word : acc_ram[src_addr];
   assign dst_word = acc_ram[dst_addr];

   mac_mul mac_mul_inst
   (
      .mult_i        (multiplier_operand_reg),
      .word_i        (src_word),
      .word_signed_i (last),
      .carry_i       (mul_carry),
      .low_o         (mul_low),
      .high_o        (mul_high)
   );

   mac_addsub mac_addsub_inst
   (
      .a_i     (dst_word),
      .b_i     (mul_low),
      .sub_i   (op_is_sub(cur_op)),
      .carry_i (add_carry),
      .sum_o   (sum),
      .carry_o (sum_carry),
      .ovf_o   (sum_ovf)
   );

   // Round on the top bit of the low word; saturate so it cannot wrap.
   assign rounded_high = (mul_high == SAT_POS) ? SAT_POS
                       : mul_high + {15'h0000, mul_low[15]};

   // =========================================================
   // Sequencer
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state <= ST_IDLE;
      else
      begin
         case (state)
            ST_IDLE:
               if (op_valid_i)
               begin
                  if (ptr_mod_i != MOD_NONE)
                     state <= ST_PREMOD;
                  else
                     state <= src_mem_i ? ST_FETCH : ST_EXEC;
               end
            ST_PREMOD:
               state <= cur_mem ? ST_FETCH : ST_EXEC;
            ST_FETCH:
               if (mem_rvalid_i)
                  state <= ST_EXEC;
            ST_EXEC:
               if (last)
                  state <= ST_DONE;
               else
                  state <= cur_mem ? ST_FETCH : ST_EXEC;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Operation fields are held for the whole operation.
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cur_op      <= OP_ROUND_MUL;
         cur_ptr_mod <= MOD_NONE;
         cur_idx_mod <= MOD_NONE;
         cur_mem     <= 1'b0;
         cur_sel     <= 2'b00;
         cur_src_off <= 1'b0;
         cur_dst_off <= 1'b0;
         last_idx    <= 5'h00;
      end
      else if (accept)
      begin
         cur_op      <= op_code_i;
         cur_ptr_mod <= ptr_mod_i;
         cur_idx_mod <= idx_mod_i;
         cur_mem     <= src_mem_i;
         cur_sel     <= acc_select_i;
         cur_src_off <= src_offset_i;
         cur_dst_off <= dst_offset_i;
         // A string spans the chain length plus two words.
         last_idx    <= op_is_chain(op_code_i)
                      ? {1'b0, chain_length_reg} + CHAIN_XTRA - 5'h01
                      : 5'h00;
      end
   end

   // Word walk: product carry, add carry and zero tracking per word.
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         word_idx  <= 5'h00;
         mul_carry <= RST_WORD;
         add_carry <= 1'b0;
         zero_run  <= 1'b1;
         mem_addr  <= RST_WORD;
      end
      else if (accept)
      begin
         word_idx  <= 5'h00;
         mul_carry <= RST_WORD;
         add_carry <= op_is_sub(op_code_i);
         zero_run  <= 1'b1;
         mem_addr  <= index_reg_three;
      end
      else if (exec)
      begin
         word_idx  <= word_idx + 5'h01;
         mul_carry <= mul_high;
         add_carry <= sum_carry;
         zero_run  <= zero_run && (sum == RST_WORD);
         mem_addr  <= mem_addr + ADDR_STEP;
      end
   end

   // Memory word capture; the tag comes from the seventeenth bit.
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         mem_word <= RST_WORD;
         tag_flag <= 1'b0;
      end
      else if ((state == ST_FETCH) && mem_rvalid_i)
      begin
         mem_word <= mem_rdata_i[15:0];
         tag_flag <= mem_rdata_i[TAG_BIT];
      end
   end

   // Product registers. The chain multiply leaves product-low alone.
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         product_high_reg <= RST_WORD;
         product_low_reg  <= RST_WORD;
      end
      else if (exec)
      begin
         if (cur_op != OP_CHAIN_MUL)
            product_low_reg <= mul_low;
         if (last)
            product_high_reg <= do_round ? rounded_high
                                         : mul_high;
      end
   end

   // Status flags follow the last word of an accumulation only.
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         overflow_flag <= 1'b0;
         sign_flag     <= 1'b0;
         zero_flag     <= 1'b0;
         carry_flag    <= 1'b0;
      end
      else if (exec && last && is_mac)
      begin
         overflow_flag <= sum_ovf;
         sign_flag     <= sum[15];
         zero_flag     <= zero_run && (sum == RST_WORD);
         carry_flag    <= sum_carry;
      end
   end

   // Accumulator file; the unit has priority over outside writes.
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < ACC_WORDS; i++)
            acc_ram[i] <= RST_WORD;
         acc_rd_data_o <= RST_WORD;
      end
      else
      begin
         if (acc_we)
            acc_ram[dst_addr] <= sum;
         else if (acc_wr_i && (state == ST_IDLE))
            acc_ram[acc_wr_addr_i] <= acc_wr_data_i;
         acc_rd_data_o <= acc_ram[acc_rd_addr_i];
      end
   end

   // Pointers: loaded while idle, stepped before the operation starts.
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < PTR_COUNT; i++)
            accumulator_pointer[i] <= RST_PTR;
      end
      else if (state == ST_PREMOD)
      begin
         if (cur_ptr_mod == MOD_INC)
            accumulator_pointer[cur_sel] <= accumulator_pointer[cur_sel]
                                          + 5'h01;
         else
            accumulator_pointer[cur_sel] <= accumulator_pointer[cur_sel]
                                          - 5'h01;
      end
      else if (ptr_load_i && (state == ST_IDLE))
         accumulator_pointer[acc_select_i] <= ptr_value_i;
   end

   // Index register: post-modified by one word after a memory operand.
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         index_reg_three <= RST_WORD;
      else if ((state == ST_DONE) && cur_mem)
      begin
         if (cur_idx_mod == MOD_INC)
            index_reg_three <= index_reg_three + ADDR_STEP;
         else if (cur_idx_mod == MOD_DEC)
            index_reg_three <= index_reg_three - ADDR_STEP;
      end
      else if (idx_load_i && (state == ST_IDLE))
         index_reg_three <= idx_value_i;
   end

   // Operand and length registers, loaded only between operations.
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         multiplier_operand_reg <= RST_WORD;
         chain_length_reg       <= RST_LEN;
      end
      else if (state == ST_IDLE)
      begin
         if (mult_load_i)
            multiplier_operand_reg <= mult_value_i;
         if (chain_len_load_i)
            chain_length_reg <= chain_len_value_i;
      end
   end

   // =========================================================
   // Outputs
   assign op_ready_o        = (state == ST_IDLE);
   assign op_done_o         = (state == ST_DONE);
   assign mem_rd_o          = (state == ST_FETCH);
   assign mem_addr_o        = mem_addr;
   assign product_high_o    = product_high_reg;
   assign product_low_o     = product_low_reg;
   assign index_reg_three_o = index_reg_three;
   assign overflow_flag_o   = overflow_flag;
   assign sign_flag_o       = sign_flag;
   assign zero_flag_o       = zero_flag;
   assign carry_flag_o      = carry_flag;
   assign tag_flag_o        = tag_flag;

   // =========================================================
   // Assertions
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_accept_acc;
      accept && !src_mem_i && (ptr_mod_i == MOD_NONE);
   endsequence

   sequence s_finish;
      ##[1:20] op_done_o;
   endsequence

   a_acc_op_ends: assert property (s_accept_acc |-> s_finish)
      else $error("Accumulator operation did not finish in time.");

   a_mul_no_write: assert property (
      exec && !is_mac && !cur_mem
      |=> acc_ram[$past(src_addr)] == $past(src_word))
      else $error("Plain multiply wrote the accumulator file.");

   a_chain_len: assert property (
      exec && last && op_is_chain(cur_op)
      |-> word_idx == {1'b0, chain_length_reg} + 5'h01)
      else $error("String length differs from chain length plus two.");

   a_round_high: assert property (
      exec && last && do_round && (mul_high != SAT_POS)
      |=> product_high_reg == $past(mul_high)
                            + {15'h0000, $past(mul_low[15])})
      else $error("Upper product word not rounded.");

   a_mem_no_round: assert property (
      exec && last && (cur_op == OP_ROUND_MUL) && cur_mem
      |=> product_high_reg == $past(mul_high))
      else $error("Memory-source multiply was rounded.");

   a_chain_keeps_low: assert property (
      exec && (cur_op == OP_CHAIN_MUL) |=> $stable(product_low_reg))
      else $error("Chain multiply changed product-low.");

   a_flags_hold: assert property (
      (state == ST_DONE) && !is_mac
      |-> $stable(zero_flag) && $stable(carry_flag)
       && $stable(sign_flag) && $stable(overflow_flag))
      else $error("Flags changed on a plain multiply.");

   a_tag_capture: assert property (
      mem_rd_o && mem_rvalid_i |=> tag_flag == $past(mem_rdata_i[16]))
      else $error("Tag not taken from the memory word.");

   a_idx_step: assert property (
      op_done_o && cur_mem && (cur_idx_mod == MOD_INC)
      |=> index_reg_three == $past(index_reg_three) + 16'h0002)
      else $error("Index register did not step by two.");

   a_premod_first: assert property (
      accept && (ptr_mod_i != MOD_NONE) |=> state == ST_PREMOD ##1
      state != ST_PREMOD)
      else $error("Pointer not modified before the multiply.");

endmodule // mac_unit

// ===== tb/tb_mac_unit.sv
`timescale 1ns/1ps
module tb_mac_unit
   import mac_pkg::*;
;
   // ====================
   // Design ports
   logic        mclk_i, nrst_i, op_valid_i, op_ready_o, op_done_o;
   logic        src_mem_i, src_offset_i, dst_offset_i;
   logic        mult_load_i, chain_len_load_i, idx_load_i, ptr_load_i;
   logic        acc_wr_i, mem_rd_o, mem_rvalid_i, tag_flag_o;
   logic        overflow_flag_o, sign_flag_o, zero_flag_o, carry_flag_o;
   logic [1:0]  acc_select_i;
   logic [3:0]  chain_len_value_i;
   logic [4:0]  ptr_value_i, acc_wr_addr_i, acc_rd_addr_i;
   logic [15:0] mult_value_i, idx_value_i, acc_wr_data_i, acc_rd_data_o;
   logic [15:0] mem_addr_o, product_high_o, product_low_o;
   logic [15:0] index_reg_three_o;
   logic [16:0] mem_rdata_i;
   mac_op_t     op_code_i;
   mac_mod_t    ptr_mod_i, idx_mod_i;
   logic [16:0] mem [4];
   int          num_errors, checked, cyc;

   mac_unit mac_unit_inst
   (
      .mclk_i, .nrst_i, .op_valid_i, .op_code_i, .src_mem_i,
      .acc_select_i, .src_offset_i, .dst_offset_i, .ptr_mod_i,
      .idx_mod_i, .op_ready_o, .op_done_o, .mult_load_i, .mult_value_i,
      .chain_len_load_i, .chain_len_value_i, .idx_load_i, .idx_value_i,
      .ptr_load_i, .ptr_value_i, .acc_wr_i, .acc_wr_addr_i,
      .acc_wr_data_i, .acc_rd_addr_i, .acc_rd_data_o, .mem_rd_o,
      .mem_addr_o, .mem_rdata_i, .mem_rvalid_i, .product_high_o,
      .product_low_o, .index_reg_three_o, .overflow_flag_o,
      .sign_flag_o, .zero_flag_o, .carry_flag_o, .tag_flag_o
   );

   // ====================
   // Clock and data memory
   // Free-running 200 MHz core clock.
   initial
   begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   // Memory answers one cycle late; idle data toggles so it is never stale.
   always @(posedge mclk_i)
   begin
      if (mem_rd_o === 1'b1 && mem_rvalid_i !== 1'b1)
      begin
         mem_rvalid_i <= 1'b1;
         mem_rdata_i  <= mem[mem_addr_o[2:1]];
      end
      else
      begin
         mem_rvalid_i <= 1'b0;
         mem_rdata_i  <= ~mem_rdata_i;
      end
   end

   // ====================
   // Tasks
   task automatic finish_test();
      if (num_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] s, e);
      checked++;
      if (s !== e)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   // Flags packed as overflow, sign, zero, carry.
   task automatic fl(input logic [3:0] e);
      chk("flags", {12'h000, overflow_flag_o, sign_flag_o, zero_flag_o,
                    carry_flag_o}, {12'h000, e});
   endtask

   // Loads are taken only while idle, so callers wait for done first.
   task automatic ld(input logic [15:0] mr, idx, input logic [3:0] len);
      @(posedge mclk_i);
      {mult_load_i, chain_len_load_i, idx_load_i, ptr_load_i} <= 4'hf;
      mult_value_i      <= mr;
      idx_value_i       <= idx;
      chain_len_value_i <= len;
      @(posedge mclk_i);
      {mult_load_i, chain_len_load_i, idx_load_i, ptr_load_i} <= 4'h0;
   endtask

   task automatic wa(input logic [4:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      acc_wr_i      <= 1'b1;
      acc_wr_addr_i <= a;
      acc_wr_data_i <= d;
      @(posedge mclk_i);
      acc_wr_i      <= 1'b0;
   endtask

   // The read port is registered, hence the second edge.
   task automatic ra(input logic [4:0] a, input logic [15:0] e);
      @(posedge mclk_i);
      acc_rd_addr_i <= a;
      repeat (2) @(posedge mclk_i);
      #1 chk("acc", acc_rd_data_o, e);
   endtask

   // Issues one operation and counts cycles from accept to done.
   task automatic op(input mac_op_t c, input logic m, so,
                     input mac_mod_t pm);
      @(posedge mclk_i);
      op_valid_i   <= 1'b1;
      op_code_i    <= c;
      src_mem_i    <= m;
      src_offset_i <= so;
      dst_offset_i <= !so && !m;
      ptr_mod_i    <= pm;
      idx_mod_i    <= m ? MOD_INC : MOD_NONE;
      @(posedge mclk_i);
      op_valid_i   <= 1'b0;
      cyc = 1;
      do
      begin
         @(posedge mclk_i);
         #1;
         cyc++;
         if (cyc > 40)
         begin
            num_errors++;
            finish_test();
         end
      end while (op_done_o !== 1'b1);
   endtask

   // ====================
   // Main sequence
   initial
   begin
      nrst_i = 1'b0;
      {op_valid_i, src_mem_i, src_offset_i, dst_offset_i} = '0;
      {mult_load_i, chain_len_load_i, idx_load_i, ptr_load_i} = '0;
      {acc_wr_i, acc_select_i, chain_len_value_i} = '0;
      {ptr_value_i, acc_wr_addr_i, acc_rd_addr_i} = '0;
      {mult_value_i, idx_value_i, acc_wr_data_i} = '0;
      op_code_i = OP_ROUND_MUL;
      ptr_mod_i = MOD_NONE;
      idx_mod_i = MOD_NONE;
      mem = '{17'h1_0003, 17'h0_7777, 17'h0_0005, 17'h0_0001};
      num_errors = 0;
      checked = 0;
      repeat (10) @(posedge mclk_i);
      nrst_i <= 1'b1;
      // Product low 0xc000 makes rounding visible in the high word.
      ld(16'h4000, 16'h0100, 4'h0);
      wa(5'h10, 16'h0003);
      op(OP_ROUND_MUL, 1'b0, 1'b1, MOD_NONE);
      chk("ph", product_high_o, 16'h0001);
      chk("pl", product_low_o, 16'hc000);
      ra(5'h10, 16'h0003);
      // Same product from memory must not round.
      op(OP_ROUND_MUL, 1'b1, 1'b0, MOD_NONE);
      chk("ph", product_high_o, 16'h0000);
      chk("tag", {15'h0000, tag_flag_o}, 16'h0001);
      ra(5'h10, 16'h0003);
      chk("idx", index_reg_three_o, 16'h0102);
      // Add that overflows into the sign bit.
      wa(5'h00, 16'h4000);
      wa(5'h10, 16'h0005);
      op(OP_MAC_ADD, 1'b0, 1'b1, MOD_NONE);
      chk("cyc", 16'(cyc), 16'h0002);
      chk("ph", product_high_o, 16'h0001);
      fl(4'hc);
      ra(5'h00, 16'h8000);
      // Subtract through a pre-incremented pointer, borrowing.
      ld(16'h0002, 16'h0100, 4'h0);
      wa(5'h01, 16'h0005);
      wa(5'h11, 16'h0003);
      op(OP_MAC_SUB, 1'b0, 1'b1, MOD_INC);
      chk("cyc", 16'(cyc), 16'h0003);
      chk("pl", product_low_o, 16'h0006);
      fl(4'h4);
      ra(5'h01, 16'hffff);
      ra(5'h00, 16'h8000);
      // Two-word chain; a third word would change the high result.
      ld(16'h4000, 16'h0104, 4'h0);
      wa(5'h10, 16'h0000);
      wa(5'h11, 16'h0002);
      wa(5'h12, 16'h7fff);
      op(OP_CHAIN_MUL, 1'b0, 1'b1, MOD_NONE);
      chk("cyc", 16'(cyc), 16'h0003);
      chk("ph", product_high_o, 16'h0001);
      chk("pl", product_low_o, 16'h0006);
      ra(5'h11, 16'h0002);
      // Chain add from memory words at index and index plus two.
      ld(16'h0001, 16'h0104, 4'h0);
      wa(5'h00, 16'h0001);
      wa(5'h01, 16'h0000);
      op(OP_CHAIN_ADD, 1'b1, 1'b0, MOD_NONE);
      ra(5'h00, 16'h0006);
      ra(5'h01, 16'h0001);
      chk("idx", index_reg_three_o, 16'h0106);
      // Chain add from the offset bank, product carries into word one.
      ld(16'h0002, 16'h0100, 4'h0);
      wa(5'h10, 16'h8000);
      wa(5'h11, 16'h0000);
      wa(5'h00, 16'h0001);
      wa(5'h01, 16'h0000);
      op(OP_CHAIN_ADD, 1'b0, 1'b1, MOD_NONE);
      fl(4'h0);
      ra(5'h00, 16'h0001);
      ra(5'h01, 16'h0001);
      // Chain subtract with a borrow across the word boundary.
      ld(16'h0001, 16'h0100, 4'h0);
      wa(5'h10, 16'h0001);
      wa(5'h00, 16'h0000);
      op(OP_CHAIN_SUB, 1'b0, 1'b1, MOD_NONE);
      fl(4'h1);
      ra(5'h00, 16'hffff);
      ra(5'h01, 16'h0000);
      // Decremented pointer wraps; destination lies in the offset bank.
      ld(16'h0003, 16'h0100, 4'h0);
      wa(5'h1f, 16'h0002);
      wa(5'h0f, 16'h0001);
      op(OP_MAC_ADD, 1'b0, 1'b0, MOD_DEC);
      chk("cyc", 16'(cyc), 16'h0003);
      ra(5'h0f, 16'h0007);
      ra(5'h1f, 16'h0002);
      finish_test();
   end

endmodule // tb_mac_unit
